// ### mfc_map.vh
`ifndef MFC_MAP_VH
`define MFC_MAP_VH

// Register byte offsets on the APB side
`define MFC_OFF_PCL 8'h00
`define MFC_OFF_CTRL 8'h04
`define MFC_OFF_STAT 8'h08

// Control register fields and reset value
`define MFC_CTRL_RUN 0
`define MFC_CTRL_IE 1
`define MFC_CTRL_RST 2'h1

// Status register field positions
`define MFC_STAT_ACC 0
`define MFC_STAT_FLG 8
`define MFC_STAT_IRQ 12

// Fixed addresses
`define MFC_RESET_VEC 12'h000
`define MFC_INT_VEC 12'h004

// Phase counter: four phases per instruction cycle
`define MFC_PH_FIRST 2'h0
`define MFC_PH_LAST 2'h3

// Return stack
`define MFC_STK_FULL 4'h8
`define MFC_STK_EMPTY 4'h0

// Instruction classes, field [15:12]
`define MFC_I_NOP 4'h0
`define MFC_I_ALU 4'h1
`define MFC_I_SKZ 4'h2
`define MFC_I_SKNZ 4'h3
`define MFC_I_JMP 4'h4
`define MFC_I_CALL 4'h5
`define MFC_I_RET 4'h6
`define MFC_I_INTERRUPT_RETURN_INSTR 4'h7
`define MFC_I_PCLA 4'h8

// ALU operations, field [11:8]
`define MFC_A_ADD 4'h0
`define MFC_A_ADC 4'h1
`define MFC_A_SUB 4'h2
`define MFC_A_SBC 4'h3
`define MFC_A_DAA 4'h4
`define MFC_A_AND 4'h5
`define MFC_A_OR 4'h6
`define MFC_A_XOR 4'h7
`define MFC_A_CPL 4'h8
`define MFC_A_RR 4'h9
`define MFC_A_RRC 4'ha
`define MFC_A_RL 4'hb
`define MFC_A_RLC 4'hc
`define MFC_A_INC 4'hd
`define MFC_A_DEC 4'he
`define MFC_A_MOV 4'hf

`endif

// ### mfc_stack.v
`timescale 1ns/1ps
`default_nettype none
`include "mfc_map.vh"

module mfc_stack (
    input wire pclk, // System clock
    input wire presetn, // Async reset, active low
    input wire push, // Push one entry
    input wire pop, // Pop one entry
    input wire [11:0] push_data, // Value pushed
    output reg [11:0] top_q, // Registered newest entry
    output reg full_q, // All eight levels used
    output reg empty_q // No level used
);
    reg [11:0] mem [0:7]; // Eight saved program counters
    reg [2:0] ptr_q; // Next free slot, wraps modulo eight
    reg [3:0] cnt_q; // Occupied levels, saturates at eight
    reg [3:0] cnt_d;

    // Storage write, no reset needed for data
    always @(posedge pclk) begin
        if (push) begin
            mem[ptr_q] <= push_data; // [RULE_15]
        end
    end

    // Next level count
    always @* begin
        cnt_d = cnt_q;
        if (push && cnt_q != `MFC_STK_FULL) begin
            cnt_d = cnt_q + 4'h1;
        end else if (pop && cnt_q != `MFC_STK_EMPTY) begin
            cnt_d = cnt_q - 4'h1;
        end
    end

    // Pointer wraps so an overflow overwrites the oldest slot
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q <= 3'h0; // [RULE_13]
            cnt_q <= `MFC_STK_EMPTY; // [RULE_13]
            full_q <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            if (push) begin
                ptr_q <= ptr_q + 3'h1; // [RULE_19]
            end else if (pop && cnt_q != `MFC_STK_EMPTY) begin
                ptr_q <= ptr_q - 3'h1;
            end
            cnt_q <= cnt_d;
            full_q <= (cnt_d == `MFC_STK_FULL);
            empty_q <= (cnt_d == `MFC_STK_EMPTY);
        end
    end

    // Registered read of the newest entry; settles one edge after the pointer or slot changes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_q <= 12'h000;
        end else begin
            top_q <= mem[ptr_q - 3'h1];
        end
    end
endmodule

`default_nettype wire

// ### mfc_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "mfc_map.vh"

module mfc_alu (
    input wire [3:0] op, // Operation select
    input wire [7:0] a, // Accumulator operand
    input wire [7:0] b, // Immediate operand
    input wire c_in, // Carry flag in
    input wire ac_in, // Half carry flag in
    input wire ov_in, // Overflow flag in
    output reg [7:0] res, // Result
    output reg c_out, // Carry, or not-borrow after subtract
    output reg ac_out, // Half carry
    output reg ov_out, // Signed overflow
    output wire z_out // Result is zero
);
    reg [8:0] s9; // Wide sum for carry
    reg [4:0] s5; // Low nibble sum for half carry
    reg [7:0] bb; // Operand after invert for subtract
    reg cy; // Carry into the adder
    reg [8:0] adj; // Decimal adjust work value

    // Combinational datapath
    always @* begin
        bb = b;
        cy = 1'b0;
        if (op == `MFC_A_SUB || op == `MFC_A_SBC) begin
            bb = ~b;
        end
        case (op)
            `MFC_A_ADC: cy = c_in;
            `MFC_A_SBC: cy = c_in;
            `MFC_A_SUB: cy = 1'b1;
            default: cy = 1'b0;
        endcase
        s9 = {1'b0, a} + {1'b0, bb} + {8'h00, cy};
        s5 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cy};
        adj = {1'b0, a};
        if (a[3:0] > 4'h9 || ac_in) begin
            adj = adj + 9'h006;
        end
        if (adj[7:4] > 4'h9 || c_in || adj[8]) begin
            adj = adj + 9'h060;
        end
        res = s9[7:0];
        c_out = c_in;
        ac_out = ac_in;
        ov_out = ov_in;
        case (op)
            `MFC_A_ADD, `MFC_A_ADC, `MFC_A_SUB, `MFC_A_SBC: begin
                c_out = s9[8]; // [RULE_16]
                ac_out = s5[4];
                ov_out = (a[7] == bb[7]) && (s9[7] != a[7]);
            end
            `MFC_A_DAA: begin
                res = adj[7:0];
                c_out = adj[8] | c_in;
            end
            `MFC_A_AND: res = a & b;
            `MFC_A_OR: res = a | b;
            `MFC_A_XOR: res = a ^ b;
            `MFC_A_CPL: res = ~a;
            `MFC_A_RR: res = {a[0], a[7:1]};
            `MFC_A_RRC: begin
                res = {c_in, a[7:1]};
                c_out = a[0];
            end
            `MFC_A_RL: res = {a[6:0], a[7]};
            `MFC_A_RLC: begin
                res = {a[6:0], c_in};
                c_out = a[7];
            end
            `MFC_A_INC: res = a + 8'h01;
            `MFC_A_DEC: res = a - 8'h01;
            default: res = b; // Move immediate
        endcase
    end

    assign z_out = (res == 8'h00);
endmodule

`default_nettype wire

// ### mfc_core.v
// Overview of operation
// (RULE_01) Four phases form one instruction cycle
// (RULE_02) Phase one increments PC and fetches
// (RULE_03) Fetch overlaps execution of current instruction
// (RULE_04) PC-changing instructions take one extra cycle
// (RULE_05) Sequential instructions advance PC by one
// (RULE_06) Twelve-bit PC, only low byte accessible
// (RULE_07) Branches, interrupts, reset load PC directly
// (RULE_08) Taken skip discards prefetch, inserts dummy
// (RULE_09) Low byte write jumps within page
// (RULE_10) Eight-level hidden stack of PC values
// (RULE_11) Call or interrupt acknowledge pushes PC
// (RULE_12) Return instructions pop stack into PC
// (RULE_13) Reset leaves stack pointer at empty
// (RULE_14) Full stack holds interrupt until return
// (RULE_15) Call on full stack still pushes
// (RULE_16) ALU writes result and updates flags
// (RULE_17) ALU covers arithmetic, logic, rotate, tests
// (RULE_18) Reset starts execution at word zero
// (RULE_19) Stack pointer wraps, oldest entry lost
// (RULE_20) Return on empty stack goes to zero
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mfc_map.vh"

module mfc_core (
    input wire pclk, // System clock, 50 MHz
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB write
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error on unmapped address
    output reg [11:0] prog_addr, // Program memory address
    output reg prog_rd, // Program memory fetch pulse
    input wire [15:0] prog_data, // Program memory word
    input wire int_req, // Interrupt request level
    output reg int_ack, // Interrupt acknowledge pulse
    output reg phase_one // First phase marker pulse
);
    // Decode of APB offsets, shared by read and write paths
    function [1:0] reg_sel;
        input [7:0] addr;
        begin
            case (addr)
                `MFC_OFF_PCL: reg_sel = 2'h1;
                `MFC_OFF_CTRL: reg_sel = 2'h2;
                `MFC_OFF_STAT: reg_sel = 2'h3;
                default: reg_sel = 2'h0;
            endcase
        end
    endfunction

    reg [1:0] phase_q; // Phase within instruction cycle
    reg [11:0] pc_q; // Program counter
    reg [15:0] ir_q; // Instruction being executed
    reg ir_vld_q; // Low during a dummy cycle

    // Datapath state
    reg [7:0] acc_q; // Accumulator
    reg c_q; // Carry flag
    reg ac_q; // Half carry flag
    reg z_q; // Zero flag
    reg ov_q; // Overflow flag

    // Control state
    reg run_q; // Core runs when set
    reg ie_q; // Interrupt enable
    reg irq_q; // Latched interrupt request
    reg pcl_pend_q; // Software low byte write waiting
    reg [7:0] pcl_data_q; // Value of that write

    wire t1; // First phase of a cycle
    wire t4; // Last phase of a cycle
    wire [3:0] cls; // Instruction class

    wire [7:0] alu_res; // ALU result
    wire alu_c; // ALU carry out
    wire alu_ac; // ALU half carry out
    wire alu_ov; // ALU overflow out
    wire alu_z; // ALU zero out

    wire [11:0] stk_top; // Newest stack entry
    wire stk_full; // Stack full
    wire stk_empty; // Stack empty

    // Bus decode
    wire [1:0] sel; // Decoded APB register
    wire apb_wr; // APB write completes this edge
    wire apb_setup; // APB setup cycle

    reg take_br; // Branch this cycle
    reg [11:0] br_target; // Branch target

    reg push_en; // Push request
    reg [11:0] push_val; // Value pushed
    reg pop_en; // Pop request

    reg acc_we; // Accumulator and flags update
    reg ie_set; // Return from interrupt
    reg take_int; // Interrupt entry this cycle
    reg pcl_take; // Pending low byte write applied

    assign t1 = run_q && (phase_q == `MFC_PH_FIRST);
    assign t4 = run_q && (phase_q == `MFC_PH_LAST);
    assign cls = ir_q[15:12];

    assign sel = reg_sel(paddr);
    assign apb_wr = psel && penable && pready && pwrite;
    assign apb_setup = psel && !penable;

    mfc_alu u_alu (
        .op(ir_q[11:8]),
        .a(acc_q),
        .b(ir_q[7:0]),
        .c_in(c_q),
        .ac_in(ac_q),
        .ov_in(ov_q),
        .res(alu_res),
        .c_out(alu_c),
        .ac_out(alu_ac),
        .ov_out(alu_ov),
        .z_out(alu_z)
    );

    mfc_stack u_stack (
        .pclk(pclk),
        .presetn(presetn),
        .push(push_en),
        .pop(pop_en),
        .push_data(push_val),
        .top_q(stk_top),
        .full_q(stk_full),
        .empty_q(stk_empty)
    );

    // Phase divider; the four phases never overlap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= `MFC_PH_FIRST;
        end else if (run_q) begin
            phase_q <= phase_q + 2'h1; // [RULE_01]
        end
    end

    // Execute decode, evaluated for the last phase
    always @* begin
        take_br = 1'b0;
        br_target = pc_q;

        push_en = 1'b0;
        push_val = pc_q - 12'h001;
        pop_en = 1'b0;

        acc_we = 1'b0;
        ie_set = 1'b0;
        take_int = 1'b0;
        pcl_take = 1'b0;
        if (t4 && ir_vld_q) begin
            case (cls)
                `MFC_I_ALU: begin
                    acc_we = 1'b1; // [RULE_16] [RULE_17]
                end

                `MFC_I_SKZ: begin
                    acc_we = 1'b1;
                    take_br = alu_z; // [RULE_08] [RULE_17]
                end

                `MFC_I_SKNZ: begin
                    acc_we = 1'b1;
                    take_br = !alu_z; // [RULE_08]
                end

                `MFC_I_JMP: begin
                    take_br = 1'b1; // [RULE_07]
                    br_target = ir_q[11:0];
                end

                `MFC_I_CALL: begin
                    take_br = 1'b1; // [RULE_07]
                    br_target = ir_q[11:0];
                    push_en = 1'b1; // [RULE_11] [RULE_15]
                end

                `MFC_I_RET, `MFC_I_INTERRUPT_RETURN_INSTR: begin
                    take_br = 1'b1;
                    pop_en = 1'b1; // [RULE_12]
                    br_target = stk_empty ? `MFC_RESET_VEC : stk_top; // [RULE_20]
                    ie_set = (cls == `MFC_I_INTERRUPT_RETURN_INSTR);
                end

                `MFC_I_PCLA: begin
                    take_br = 1'b1; // [RULE_09]
                    br_target = {pc_q[11:8], acc_q};
                end

                default: begin
                    take_br = 1'b0;
                end
            endcase
        end

        // Software write waits for a cycle with no branch of its own
        if (t4 && !take_br && pcl_pend_q) begin
            take_br = 1'b1; // [RULE_09]
            pcl_take = 1'b1;
            br_target = {pc_q[11:8], pcl_data_q};
        end

        // Interrupt only when a level is free; the prefetch is replayed
        if (t4 && !take_br && irq_q && ie_q && !stk_full) begin
            take_br = 1'b1; // [RULE_14]
            take_int = 1'b1;
            push_en = 1'b1; // [RULE_11]
            br_target = `MFC_INT_VEC; // [RULE_07]
        end
    end

    // Program counter, fetch and pipeline register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= `MFC_RESET_VEC; // [RULE_18]
            prog_addr <= `MFC_RESET_VEC;
            prog_rd <= 1'b0;
            phase_one <= 1'b0;
            ir_q <= 16'h0000;
            ir_vld_q <= 1'b0;
        end else begin
            prog_rd <= t1;
            phase_one <= t1;

            // Fetch at phase one
            if (t1) begin
                prog_addr <= pc_q; // [RULE_02]
                pc_q <= pc_q + 12'h001; // [RULE_02] [RULE_05]
            end

            // Then execute or branch
            if (t4) begin
                if (take_br) begin
                    pc_q <= br_target; // [RULE_04] [RULE_07]
                    ir_vld_q <= 1'b0; // [RULE_08]
                end else begin
                    ir_q <= prog_data; // [RULE_03]
                    ir_vld_q <= 1'b1;
                end
            end
        end
    end

    // Accumulator and status flags
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 8'h00;
            c_q <= 1'b0;
            ac_q <= 1'b0;
            z_q <= 1'b0;
            ov_q <= 1'b0;
        end else if (acc_we) begin
            acc_q <= alu_res; // [RULE_16]
            c_q <= alu_c;
            ac_q <= alu_ac;
            z_q <= alu_z;
            ov_q <= alu_ov;
        end
    end

    // Interrupt latch; a new request wins over the acknowledge clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            int_ack <= 1'b0;
        end else begin
            int_ack <= take_int;

            if (int_req && ie_q) begin
                irq_q <= 1'b1; // [RULE_14]
            end else if (take_int) begin
                irq_q <= 1'b0;
            end
        end
    end

    // Control bits; hardware entry and return override software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= |(`MFC_CTRL_RST & (2'h1 << `MFC_CTRL_RUN));
            ie_q <= 1'b0;
        end else begin
            if (apb_wr && sel == 2'h2) begin
                run_q <= pwdata[`MFC_CTRL_RUN];
                ie_q <= pwdata[`MFC_CTRL_IE];
            end

            if (take_int) begin
                ie_q <= 1'b0;
            end else if (ie_set) begin
                ie_q <= 1'b1;
            end
        end
    end

    // Pending low byte write; a new write wins over the consume
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcl_pend_q <= 1'b0;
            pcl_data_q <= 8'h00;
        end else if (apb_wr && sel == 2'h1) begin
            pcl_pend_q <= 1'b1; // [RULE_06] [RULE_09]
            pcl_data_q <= pwdata[7:0];
        end else if (pcl_take) begin
            pcl_pend_q <= 1'b0;
        end
    end

    // APB slave: data in setup, ready in first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && (sel == 2'h0);

            if (apb_setup) begin
                case (sel)
                    2'h1: prdata <= {24'h00_0000, pc_q[7:0]}; // [RULE_06]
                    2'h2: prdata <= {30'h0000_0000, ie_q, run_q};
                    // Stack contents and level stay hidden
                    2'h3: prdata <= {19'h0_0000, irq_q, ov_q, z_q, ac_q, c_q, acc_q}; // [RULE_10]
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// ### mfc_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mfc_core_sva (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Direction
    input wire logic [7:0] paddr, // Byte address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [11:0] prog_addr, // Fetch address
    input wire logic prog_rd, // Fetch pulse
    input wire logic [15:0] prog_data, // Fetched word
    input wire logic int_req, // Request level
    input wire logic int_ack, // Acknowledge pulse
    input wire logic phase_one // First phase marker
);
    // All checks live in the one clock domain
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_phase_gap: assert property (prog_rd |=> !prog_rd [*3])
        else $error("fetch pulses closer than four cycles");
    a_phase_mark: assert property (phase_one == prog_rd)
        else $error("phase marker apart from fetch");
    a_addr_hold: assert property (prog_rd |=> $stable(prog_addr) [*3])
        else $error("fetch address moved inside a cycle");
    a_reset_fetch: assert property ($rose(presetn) |-> ##[1:2] (prog_rd && prog_addr == 12'h000))
        else $error("first fetch not at word zero");
    a_ack_once: assert property (int_ack |=> !int_ack)
        else $error("acknowledge longer than one cycle");
    a_ack_vec: assert property (int_ack |-> ##[0:4] (prog_rd && prog_addr == 12'h004))
        else $error("no vector fetch after acknowledge");
    a_ack_cause: assert property (int_ack |-> $past(int_req))
        else $error("acknowledge without request");
    a_apb_answer: assert property ((psel && !penable) |=> pready ##1 !pready)
        else $error("ready not a single access cycle");
    a_unmapped_err: assert property ((pready && paddr > 8'h08) |-> pslverr)
        else $error("unmapped access without error");
    a_pcl_high: assert property ((pready && !pwrite && paddr == 8'h00) |-> prdata[31:8] == 24'h00_0000)
        else $error("high counter bits visible");

    // Main scenarios reached
    c_irq: cover property (int_ack);
    c_err: cover property (pready && pslverr);
    c_page: cover property (prog_rd && prog_addr == 12'h060);
endmodule
`default_nettype wire

// ### mfc_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mfc_prog_mem (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic [11:0] prog_addr, // Fetch address
    input wire logic prog_rd, // Fetch pulse
    output logic [15:0] prog_data, // Returned word
    input wire logic int_ack, // Acknowledge from core
    input wire logic raise, // Bench asks for a request
    output logic int_req // Request level
);
    logic [15:0] mem [0:4095]; // Word store
    logic [11:0] addr_q; // Address of the open fetch
    logic [1:0] cnt_q; // Cycles since the fetch pulse

    // Empty words decode as no-op
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
    end

    // Track the fetch; word is owed only in its last cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'h0;
            addr_q <= 12'h000;
        end else if (prog_rd) begin
            cnt_q <= 2'h1;
            addr_q <= prog_addr;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    // Outside the hold window show the inverse, so a late sample is caught
    assign prog_data = (cnt_q == 2'h2) ? mem[addr_q] : ~mem[addr_q];

    // Request held until acknowledged, as a level source does
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_req <= 1'b0;
        end else if (int_ack) begin
            int_req <= 1'b0;
        end else if (raise) begin
            int_req <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### mfc_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mfc_core_tb_top;
    typedef struct packed {
        logic [31:0] d; // Expected read data
        logic [31:0] m; // Compared bits
        logic e; // Expected error
    } mfc_exp_t;
    logic pclk = 1'b0; // 50 MHz
    logic presetn = 1'b0; // Reset, active low
    logic psel = 1'b0; // Bus controls
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic raise = 1'b0; // Interrupt trigger
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] prog_addr;
    logic prog_rd;
    logic [15:0] prog_data;
    logic int_req;
    logic int_ack;
    logic phase_one;
    int fails = 0; // Mismatches
    int n_compared = 0; // Comparisons
    logic [31:0] acks = 32'h0; // Acknowledges seen
    logic [15:0] seed = 16'hcc9c; // Random state
    mfc_exp_t cur; // Note being compared
    mfc_exp_t exp_a [$]; // Bus notes
    logic [11:0] exp_f [$]; // Fetch notes
    // Program: address and word; calls nest eight deep at 040
    logic [27:0] prog_tab [0:21] = '{28'h000_1f05, 28'h001_5010, 28'h002_4020,
        28'h010_2205, 28'h011_43ff, 28'h012_6000, 28'h020_1f34, 28'h021_8000,
        28'h034_3f00, 28'h035_4040, 28'h040_5041, 28'h041_5042, 28'h042_5043,
        28'h043_5044, 28'h044_5045, 28'h045_5046, 28'h046_5047, 28'h047_5048,
        28'h048_4048, 28'h060_6000, 28'h004_7000, 28'h005_0000};
    // Fetch order up to the call chain, discarded slots included
    logic [11:0] fseq [0:15] = '{12'h000, 12'h001, 12'h002, 12'h010, 12'h011,
        12'h012, 12'h013, 12'h002, 12'h003, 12'h020, 12'h021, 12'h022, 12'h034,
        12'h035, 12'h036, 12'h040};

    always #10 pclk = ~pclk;

    mfc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .prog_rd(prog_rd),
        .prog_data(prog_data), .int_req(int_req), .int_ack(int_ack),
        .phase_one(phase_one));
    mfc_prog_mem i_mem (.pclk(pclk), .presetn(presetn), .prog_addr(prog_addr),
        .prog_rd(prog_rd), .prog_data(prog_data), .int_ack(int_ack), .raise(raise),
        .int_req(int_req));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One bus transfer; request held until ready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        int n;
        n = 0;
        exp_a.push_back({d & m, m, e});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) fails++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Wait for a fetch of one address among the next n fetches
    task automatic wait_fetch(input logic [11:0] a, input int n);
        int k;
        k = 0;
        while (k < n) begin
            @(posedge pclk);
            if (prog_rd === 1'b1 && prog_addr === a) break;
            if (prog_rd === 1'b1) k++;
        end
        check({20'h0_0000, (k < n) ? a : ~a}, {20'h0_0000, a});
    endtask

    task automatic push_prog;
        foreach (fseq[i]) exp_f.push_back(fseq[i]);
        for (int i = 1; i <= 8; i++) begin
            exp_f.push_back(12'h040 + i[11:0]);
            exp_f.push_back(12'h040 + i[11:0]);
        end
        exp_f.push_back(12'h049);
        exp_f.push_back(12'h048);
    endtask

    task automatic drain;
        int n;
        n = 0;
        while (exp_f.size() > 0 && n < 800) begin
            @(posedge pclk);
            n++;
        end
        check(32'(exp_f.size()), 32'h0);
    endtask

    // Fetch watcher: oldest note against each fetch pulse
    always @(posedge pclk) begin
        if (presetn && prog_rd === 1'b1 && exp_f.size() > 0) begin
            check({20'h0_0000, prog_addr}, {20'h0_0000, exp_f.pop_front()});
        end
    end

    // Bus watcher: data and error taken at the completing edge
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            cur = exp_a.pop_front();
            check(prdata & cur.m, cur.d);
            check({31'h0, pslverr}, {31'h0, cur.e});
        end
        if (int_ack === 1'b1) acks <= acks + 32'h1;
    end

    // Watchdog: the run needs about 450 cycles
    initial begin
        repeat (8000) @(posedge pclk);
        fails++;
        end_sim();
    end

    initial begin
        #1;
        foreach (prog_tab[i]) i_mem.mem[prog_tab[i][27:16]] = prog_tab[i][15:0];
        push_prog();
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        drain();
        $display("test program flow done");
        apb(1'b0, 8'h04, 32'h0000_0001, 32'hffff_ffff, 1'b0);
        apb(1'b0, 8'h00, 32'h0000_0000, 32'hffff_ff00, 1'b0);
        apb(1'b0, 8'h08, 32'h0000_0000, 32'h0000_00ff, 1'b0);
        // Random unmapped places must refuse and change nothing
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            apb(1'b1, 8'h10 | {seed[7:2], 2'b00}, {seed, seed}, 32'h0, 1'b1);
            apb(1'b0, 8'h10 | {seed[13:8], 2'b00}, 32'h0, 32'hffff_ffff, 1'b1);
        end
        apb(1'b0, 8'h04, 32'h0000_0001, 32'hffff_ffff, 1'b0);
        $display("test registers done");
        // Stack is full here: request is latched but not served
        apb(1'b1, 8'h04, 32'h0000_0003, 32'h0, 1'b0);
        @(posedge pclk);
        raise <= 1'b1;
        @(posedge pclk);
        raise <= 1'b0;
        repeat (80) @(posedge pclk);
        check(acks, 32'h0);
        apb(1'b0, 8'h08, 32'h0000_1000, 32'h0000_1000, 1'b0);
        apb(1'b1, 8'h00, 32'h0000_0060, 32'h0, 1'b0);
        wait_fetch(12'h060, 6);
        wait_fetch(12'h004, 6);
        check(acks, 32'h1);
        wait_fetch(12'h048, 6);
        $display("test interrupt hold done");
        // Reset in mid-run restarts the same flow
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        check({20'h0_0000, prog_addr}, 32'h0);
        push_prog();
        presetn <= 1'b1;
        drain();
        $display("test second reset done");
        end_sim();
    end
endmodule

bind mfc_core mfc_core_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_data(prog_data), .int_req(int_req),
    .int_ack(int_ack), .phase_one(phase_one));
`default_nettype wire
